// *** core/cpa_pwm16.sv ***
/*
 * cpa_pwm16: counter array with three 16-bit pulse-width modules, control
 * register, per-module mode and compare registers, and one interrupt line.
 * Assumes a single 100 MHz clock; the counter counts every cycle it runs.
 */
// Local design decision: strobed register access.
// Summary of operation
// - in 16-bit pulse-width mode, output goes high when counter equals compare
// - in 16-bit pulse-width mode, output goes low when the counter overflows
// - mode active only with compare, pulse-width and wide select all set
// - mode ignores the narrow pulse-width modes, using all 16 compare bits
// - with match flag enable set, each match sets the module match flag
// - writing the compare low byte clears compare enable
// - writing the compare high byte sets compare enable
// - high fraction is 65536 minus compare over 65536
// - compare enable clear gives a constant low output
// - overflow flag bit 7 set on rollover, interrupts, held until cleared
// - run bit 6 halts the counter at zero, lets it count at one
// - bits 2:0 set on module match, interrupt, held until cleared
// - control bits 5:3 read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module cpa_pwm16 (
   input  wire logic                         CLK,
   input  wire logic                         RESET,
   input  wire logic                         WR_STB,
   input  wire logic                         RD_STB,
   input  wire logic [cpa_pkg::ADDR_W-1:0]   ADDR,
   input  wire logic [cpa_pkg::DATA_W-1:0]   WDATA,
   output logic      [cpa_pkg::DATA_W-1:0]   RDATA,
   output logic      [cpa_pkg::NUM_MOD-1:0]  MODULE_OUTPUT_PIN,
   output logic                              IRQ
);
   import cpa_pkg::*;

   cpa_req_t                 req;
   logic [CNT_W-1:0]         count_reg;
   logic [CNT_W-1:0]         count_next;
   logic                     overflow_flag_reg;
   logic                     run_reg;
   logic [NUM_MOD-1:0]       match_flags_reg;
   logic [7:0]               mode_reg    [NUM_MOD];
   logic [CNT_W-1:0]         compare_reg [NUM_MOD];
   logic [NUM_MOD-1:0]       pin_reg;
   logic [NUM_MOD-1:0]       match;
   logic [NUM_MOD-1:0]       pwm16;
   logic                     rollover;
   logic [DATA_W-1:0]        rdata_next;
   logic [DATA_W-1:0]        rdata_reg;
   logic [NUM_MOD:0]         irq_mask_reg;
   logic [NUM_MOD:0]         irq_stat_reg;
   logic [NUM_MOD:0]         irq_event;
   logic                     ctrl_wr;

   // decode a per-module address; returns NUM_MOD when no module matches
   function automatic int mod_sel(input logic [7:0] a,
                                  input logic [7:0] base);
      int r;
      r = NUM_MOD;
      for (int i = 0; i < NUM_MOD; i++) begin
         if (a == base + 8'(i)) begin
            r = i;
         end
      end
      return r;
   endfunction

   assign req = '{wr: WR_STB, rd: RD_STB, addr: ADDR, wdata: WDATA};
   assign ctrl_wr = req.wr && (req.addr == CTRL_ADDR);
   assign count_next = count_reg + CNT_ONE;
   assign rollover = run_reg && (count_reg == CNT_MAX);

   // module mode decode and comparator
   always_comb begin
      for (int i = 0; i < NUM_MOD; i++) begin
         pwm16[i] = mode_reg[i][MODE_CMP_BIT] && mode_reg[i][MODE_PWM_BIT]
                    && mode_reg[i][MODE_WID_BIT];
         // full 16-bit compare, narrow modes play no part; the next
         // count is compared so the registered pin lines up with it
         match[i] = mode_reg[i][MODE_CMP_BIT] && run_reg
                    && (count_next == compare_reg[i]);
      end
   end

   // free counter; steps only while run is set
   always_ff @(posedge CLK) begin
      if (RESET) begin
         count_reg <= CNT_ZERO;
      end else if (run_reg) begin
         count_reg <= count_next;
      end
   end

   // run control bit
   always_ff @(posedge CLK) begin
      if (RESET) begin
         run_reg <= CTRL_RESET[CTRL_RUN_BIT];
      end else if (ctrl_wr) begin
         run_reg <= req.wdata[CTRL_RUN_BIT];
      end
   end

   // overflow flag: hardware set wins over a software clear
   always_ff @(posedge CLK) begin
      if (RESET) begin
         overflow_flag_reg <= CTRL_RESET[CTRL_OVF_BIT];
      end else if (rollover) begin
         overflow_flag_reg <= 1'b1;
      end else if (ctrl_wr) begin
         overflow_flag_reg <= req.wdata[CTRL_OVF_BIT];
      end
   end

   // module match flags, set wins over clear
   always_ff @(posedge CLK) begin
      if (RESET) begin
         match_flags_reg <= CTRL_RESET[NUM_MOD-1:0];
      end else begin
         for (int i = 0; i < NUM_MOD; i++) begin
            if (match[i] && mode_reg[i][MODE_MAT_BIT]) begin
               match_flags_reg[i] <= 1'b1;
            end else if (ctrl_wr) begin
               match_flags_reg[i] <= req.wdata[i];
            end
         end
      end
   end

   // mode registers; compare byte writes steer compare enable
   always_ff @(posedge CLK) begin
      if (RESET) begin
         for (int i = 0; i < NUM_MOD; i++) begin
            mode_reg[i] <= MODE_RESET;
         end
      end else if (req.wr) begin
         for (int i = 0; i < NUM_MOD; i++) begin
            if (mod_sel(req.addr, MODE_BASE) == i) begin
               mode_reg[i] <= req.wdata;
            end else if (mod_sel(req.addr, CMPL_BASE) == i) begin
               mode_reg[i][MODE_CMP_BIT] <= 1'b0;
            end else if (mod_sel(req.addr, CMPH_BASE) == i) begin
               mode_reg[i][MODE_CMP_BIT] <= 1'b1;
            end
         end
      end
   end

   // compare values; software orders low then high byte
   always_ff @(posedge CLK) begin
      if (RESET) begin
         for (int i = 0; i < NUM_MOD; i++) begin
            compare_reg[i] <= CNT_ZERO;
         end
      end else if (req.wr) begin
         for (int i = 0; i < NUM_MOD; i++) begin
            if (mod_sel(req.addr, CMPL_BASE) == i) begin
               compare_reg[i][7:0] <= req.wdata;
            end
            if (mod_sel(req.addr, CMPH_BASE) == i) begin
               compare_reg[i][15:8] <= req.wdata;
            end
         end
      end
   end

   // pulse output: high on match, low on overflow; the pin is high while
   // the counter sits in compare..0xFFFF, so compare 0 never drops it and
   // compare 0xFFFF gives one cycle high per period
   always_ff @(posedge CLK) begin
      if (RESET) begin
         pin_reg <= '0;
      end else begin
         for (int i = 0; i < NUM_MOD; i++) begin
            if (!pwm16[i]) begin
               pin_reg[i] <= 1'b0;
            end else if (match[i]) begin
               pin_reg[i] <= 1'b1;
            end else if (rollover) begin
               pin_reg[i] <= 1'b0;
            end
         end
      end
   end
   assign MODULE_OUTPUT_PIN = pin_reg;

   // interrupt events: modules in low bits, overflow on top
   always_comb begin
      for (int i = 0; i < NUM_MOD; i++) begin
         irq_event[i] = match[i] && mode_reg[i][MODE_MAT_BIT]
                        && mode_reg[i][MODE_IRQ_BIT];
      end
      irq_event[NUM_MOD] = rollover;
   end

   // sticky status, write one to clear, set wins
   always_ff @(posedge CLK) begin
      if (RESET) begin
         irq_stat_reg <= '0;
      end else if (req.wr && req.addr == ISTA_ADDR) begin
         irq_stat_reg <= (irq_stat_reg & ~req.wdata[NUM_MOD:0]) | irq_event;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_event;
      end
   end

   // interrupt mask
   always_ff @(posedge CLK) begin
      if (RESET) begin
         irq_mask_reg <= '0;
      end else if (req.wr && req.addr == IMSK_ADDR) begin
         irq_mask_reg <= req.wdata[NUM_MOD:0];
      end
   end
   assign IRQ = |(irq_stat_reg & irq_mask_reg);

   // read mux; unmapped addresses read zero
   always_comb begin
      int m;
      m = NUM_MOD;
      rdata_next = '0;
      if (req.addr == CTRL_ADDR) begin
         rdata_next[CTRL_OVF_BIT] = overflow_flag_reg;
         rdata_next[CTRL_RUN_BIT] = run_reg;
         rdata_next[NUM_MOD-1:0]  = match_flags_reg;
      end else if (req.addr == CNTL_ADDR) begin
         rdata_next = count_reg[7:0];
      end else if (req.addr == CNTH_ADDR) begin
         rdata_next = count_reg[15:8];
      end else if (req.addr == IMSK_ADDR) begin
         rdata_next[NUM_MOD:0] = irq_mask_reg;
      end else if (req.addr == ISTA_ADDR) begin
         rdata_next[NUM_MOD:0] = irq_stat_reg;
      end else begin
         m = mod_sel(req.addr, MODE_BASE);
         if (m < NUM_MOD) rdata_next = mode_reg[m];
         m = mod_sel(req.addr, CMPL_BASE);
         if (m < NUM_MOD) rdata_next = compare_reg[m][7:0];
         m = mod_sel(req.addr, CMPH_BASE);
         if (m < NUM_MOD) rdata_next = compare_reg[m][15:8];
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rdata_reg <= '0;
      end else if (req.rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= '0;
      end
   end
   assign RDATA = rdata_reg;

   // assertions
   AST_HIGH_ON_MATCH: assert property (@(posedge CLK) disable iff (RESET)
      (pwm16[0] && match[0]) |=> MODULE_OUTPUT_PIN[0])
      else $error("output not high after match");
   AST_LOW_ON_OVF: assert property (@(posedge CLK) disable iff (RESET)
      (pwm16[0] && rollover && !match[0]) |=> !MODULE_OUTPUT_PIN[0])
      else $error("output not low after overflow");
   AST_MODE_GATE: assert property (@(posedge CLK) disable iff (RESET)
      !pwm16[1] |=> !MODULE_OUTPUT_PIN[1])
      else $error("output high outside pulse-width mode");
   AST_CMP_OFF_LOW: assert property (@(posedge CLK) disable iff (RESET)
      !mode_reg[2][MODE_CMP_BIT] |=> !MODULE_OUTPUT_PIN[2])
      else $error("output high with compare disabled");
   AST_LOW_WR_CLR: assert property (@(posedge CLK) disable iff (RESET)
      (req.wr && req.addr == CMPL_BASE) |=> !mode_reg[0][MODE_CMP_BIT])
      else $error("low byte write kept compare enable");
   AST_HIGH_WR_SET: assert property (@(posedge CLK) disable iff (RESET)
      (req.wr && req.addr == CMPH_BASE) |=> mode_reg[0][MODE_CMP_BIT])
      else $error("high byte write left compare disabled");
   AST_OVF_FLAG: assert property (@(posedge CLK) disable iff (RESET)
      (run_reg && count_reg == CNT_MAX) |=> overflow_flag_reg ##0
      count_reg == CNT_ZERO)
      else $error("rollover did not set overflow flag");
   AST_RUN_HOLD: assert property (@(posedge CLK) disable iff (RESET)
      !run_reg |=> count_reg == $past(count_reg))
      else $error("counter moved while halted");
   AST_COUNT_STEP: assert property (@(posedge CLK) disable iff (RESET)
      run_reg |=> count_reg == $past(count_reg) + CNT_ONE)
      else $error("counter did not step by one");
   AST_MATCH_FLAG: assert property (@(posedge CLK) disable iff (RESET)
      (match[1] && mode_reg[1][MODE_MAT_BIT]) |=> match_flags_reg[1])
      else $error("match flag not set");
   AST_FLAG_HOLD: assert property (@(posedge CLK) disable iff (RESET)
      (match_flags_reg[0] && !ctrl_wr) |=> match_flags_reg[0])
      else $error("match flag dropped without a write");
   AST_UNUSED_ZERO: assert property (@(posedge CLK) disable iff (RESET)
      (req.rd && req.addr == CTRL_ADDR) |=> RDATA[5:3] == 3'h0)
      else $error("unused control bits read nonzero");
   AST_HIGH_ON_MATCH1: assert property (@(posedge CLK) disable iff (RESET)
      (pwm16[1] && match[1]) |=> MODULE_OUTPUT_PIN[1])
      else $error("module 1 output not high after match");
   AST_LOW_ON_OVF1: assert property (@(posedge CLK) disable iff (RESET)
      (pwm16[1] && rollover && !match[1]) |=> !MODULE_OUTPUT_PIN[1])
      else $error("module 1 output not low after overflow");
   AST_HIGH_SPAN0: assert property (@(posedge CLK) disable iff (RESET)
      (pwm16[0] && MODULE_OUTPUT_PIN[0]) |-> count_reg >= compare_reg[0])
      else $error("module 0 output high below compare value");
   AST_HIGH_SPAN1: assert property (@(posedge CLK) disable iff (RESET)
      (pwm16[1] && MODULE_OUTPUT_PIN[1]) |-> count_reg >= compare_reg[1])
      else $error("module 1 output high below compare value");
   AST_BYTE_MATCH: assert property (@(posedge CLK) disable iff (RESET)
      (pwm16[1] && !MODULE_OUTPUT_PIN[1]
       && count_next[7:0] == compare_reg[1][7:0]
       && count_next[15:8] != compare_reg[1][15:8])
      |=> !MODULE_OUTPUT_PIN[1])
      else $error("low byte match alone raised the output");
   AST_CMP_OFF_LOW0: assert property (@(posedge CLK) disable iff (RESET)
      !mode_reg[0][MODE_CMP_BIT] |=> !MODULE_OUTPUT_PIN[0])
      else $error("module 0 output high with compare disabled");
   AST_MATCH_FLAG0: assert property (@(posedge CLK) disable iff (RESET)
      (match[0] && mode_reg[0][MODE_MAT_BIT]) |=> match_flags_reg[0])
      else $error("module 0 match flag not set");
   AST_NO_FLAG2: assert property (@(posedge CLK) disable iff (RESET)
      (!match_flags_reg[2] && !mode_reg[2][MODE_MAT_BIT] && !ctrl_wr)
      |=> !match_flags_reg[2])
      else $error("match flag set without match flag enable");
   AST_OVF_HOLD: assert property (@(posedge CLK) disable iff (RESET)
      (overflow_flag_reg && !ctrl_wr) |=> overflow_flag_reg)
      else $error("overflow flag dropped without a write");
   AST_OVF_CLEAR: assert property (@(posedge CLK) disable iff (RESET)
      (ctrl_wr && !req.wdata[CTRL_OVF_BIT] && !rollover)
      |=> !overflow_flag_reg)
      else $error("overflow flag not cleared by software");
   AST_OVF_STATUS: assert property (@(posedge CLK) disable iff (RESET)
      rollover |=> irq_stat_reg[NUM_MOD])
      else $error("overflow did not raise its status bit");
   AST_MATCH_IRQ: assert property (@(posedge CLK) disable iff (RESET)
      (match[0] && mode_reg[0][MODE_MAT_BIT] && mode_reg[0][MODE_IRQ_BIT])
      |=> irq_stat_reg[0])
      else $error("match did not raise its status bit");
   AST_STAT_HOLD: assert property (@(posedge CLK) disable iff (RESET)
      (irq_stat_reg[NUM_MOD] && !(req.wr && req.addr == ISTA_ADDR))
      |=> irq_stat_reg[NUM_MOD])
      else $error("status bit dropped without a clear");
   AST_RUN_SET: assert property (@(posedge CLK) disable iff (RESET)
      (ctrl_wr && req.wdata[CTRL_RUN_BIT]) |=> run_reg)
      else $error("run bit not set by write");
   AST_RUN_READ: assert property (@(posedge CLK) disable iff (RESET)
      (req.rd && req.addr == CTRL_ADDR)
      |=> RDATA[CTRL_RUN_BIT] == $past(run_reg))
      else $error("run bit read back wrong");
endmodule
`default_nettype wire

// *** core/cpa_pkg.sv ***
/*
 * cpa_pkg: shared constants and types of the counter array pulse-width block.
 * Assumes a plain register port with byte-wide data and one system clock.
 */
package cpa_pkg;
   localparam int NUM_MOD = 3;                  // modules in the array
   localparam int CNT_W   = 16;                 // counter and compare width
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 8;

   // register offsets
   localparam logic [7:0] CTRL_ADDR  = 8'hD8;   // counter_array_control
   localparam logic [7:0] CNTL_ADDR  = 8'h00;   // counter low byte (read)
   localparam logic [7:0] CNTH_ADDR  = 8'h01;   // counter high byte (read)
   localparam logic [7:0] MODE_BASE  = 8'h10;   // module_mode_register n
   localparam logic [7:0] CMPL_BASE  = 8'h20;   // compare_value_low n
   localparam logic [7:0] CMPH_BASE  = 8'h30;   // compare_value_high n
   localparam logic [7:0] IMSK_ADDR  = 8'h40;   // interrupt mask
   localparam logic [7:0] ISTA_ADDR  = 8'h41;   // interrupt status, w1c

   // control register fields
   localparam int CTRL_OVF_BIT = 7;
   localparam int CTRL_RUN_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // mode register fields
   localparam int MODE_CMP_BIT = 6;             // compare_enable
   localparam int MODE_MAT_BIT = 3;             // match_flag_enable
   localparam int MODE_PWM_BIT = 1;             // pulse_width_enable
   localparam int MODE_IRQ_BIT = 0;             // match_irq_enable
   localparam int MODE_WID_BIT = 7;             // wide_pulse_select
   localparam logic [7:0] MODE_RESET = 8'h00;

   localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } cpa_req_t;
endpackage

// *** tb/cpa_load_model.sv ***
/*
 * cpa_load_model: external load on the module output pins; it measures the
 * high time of every pulse on each pin.
 * Assumes registered pins that change just after the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module cpa_load_model (
   input  wire logic                                     clk,
   input  wire logic                                     reset,
   input  wire logic [cpa_pkg::NUM_MOD-1:0]              pin,
   output logic      [cpa_pkg::NUM_MOD-1:0][cpa_pkg::CNT_W:0] width
);
   import cpa_pkg::*;
   logic [NUM_MOD-1:0][CNT_W:0] run_cnt;

   // count high cycles and latch them when the pulse ends, so the bench
   // can read a stable width long after the falling edge
   always_ff @(posedge clk) begin
      for (int i = 0; i < NUM_MOD; i++) begin
         if (reset) begin
            run_cnt[i] <= '0;
            width[i]   <= '0;
         end else if (pin[i]) begin
            run_cnt[i] <= run_cnt[i] + 1'b1;
         end else if (run_cnt[i] != '0) begin
            width[i]   <= run_cnt[i];
            run_cnt[i] <= '0;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/cpa_pwm16_tb.sv ***
/*
 * cpa_pwm16_tb: register-level tests of the 16-bit pulse-width counter array.
 * Assumes the register port of the package and one full counter period
 * (65536 cycles) fitting inside the watchdog span.
 */
`timescale 1ns/1ps
`default_nettype none
module cpa_pwm16_tb;
   import cpa_pkg::*;
   logic                            CLK;
   logic                            RESET;
   logic                            WR_STB;
   logic                            RD_STB;
   logic [ADDR_W-1:0]               ADDR;
   logic [DATA_W-1:0]               WDATA;
   logic [DATA_W-1:0]               RDATA;
   logic [NUM_MOD-1:0]              MODULE_OUTPUT_PIN;
   logic                            IRQ;
   logic [NUM_MOD-1:0][CNT_W:0]     width;
   int                              bad_count = 0;
   int                              checked = 0;

   cpa_pwm16 dut (.CLK(CLK), .RESET(RESET), .WR_STB(WR_STB), .RD_STB(RD_STB),
      .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA),
      .MODULE_OUTPUT_PIN(MODULE_OUTPUT_PIN), .IRQ(IRQ));
   cpa_load_model load (.clk(CLK), .reset(RESET), .pin(MODULE_OUTPUT_PIN),
      .width(width));

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      WR_STB <= 1'b1;
      ADDR   <= a;
      WDATA  <= d;
      @(posedge CLK);
      WR_STB <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge CLK);
      RD_STB <= 1'b1;
      ADDR   <= a;
      @(posedge CLK);
      RD_STB <= 1'b0;
      #1;
      d = RDATA;
   endtask

   task automatic chk(input string n, input logic [16:0] e,
                      input logic [16:0] g);
      checked++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask

   task automatic rchk(input string n, input logic [7:0] a,
                       input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(n, {9'h000, e}, {9'h000, d});
   endtask

   task automatic close_out;
      $display("counts: %0d checked, %0d bad", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // one period plus setup is about 66000 cycles
   initial begin
      #900000;
      bad_count++;
      close_out();
   end

   initial begin
      logic [7:0] c0;
      logic [7:0] c1;
      logic [7:0] v;
      int         n;
      RESET = 1'b1;
      WR_STB = 1'b0;
      RD_STB = 1'b0;
      ADDR = '0;
      WDATA = '0;
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      rchk("ctrl reset", CTRL_ADDR, CTRL_RESET);
      rchk("mode0 reset", MODE_BASE, MODE_RESET);
      wr(8'h7F, 8'hFF);
      rchk("unmapped", 8'h7F, 8'h00);
      wr(CTRL_ADDR, 8'h38);
      rchk("ctrl unused", CTRL_ADDR, 8'h00);
      rd(CNTL_ADDR, c0);
      rd(CNTL_ADDR, c1);
      chk("halted count", {9'h000, c0}, {9'h000, c1});
      $display("test registers done");
      // low byte always before high byte
      wr(MODE_BASE, 8'hCB);
      wr(CMPL_BASE, 8'h02);
      rchk("mode0 after low", MODE_BASE, 8'h8B);
      wr(CMPH_BASE, 8'h00);
      rchk("mode0 after high", MODE_BASE, 8'hCB);
      wr(MODE_BASE + 8'h01, 8'hCA);
      wr(CMPL_BASE + 8'h01, 8'hFE);
      wr(CMPH_BASE + 8'h01, 8'hFF);
      // module 2 lacks the wide select, so it must stay quiet
      wr(MODE_BASE + 8'h02, 8'h42);
      wr(CMPL_BASE + 8'h02, 8'h00);
      wr(CMPH_BASE + 8'h02, 8'h10);
      wr(IMSK_ADDR, 8'h00);
      wr(CTRL_ADDR, 8'h40);
      repeat (10) @(posedge CLK);
      rd(CNTL_ADDR, c0);
      rd(CNTL_ADDR, c1);
      chk("count step", 17'd2, {9'h000, 8'(c1 - c0)});
      rchk("ctrl match", CTRL_ADDR, 8'h41);
      rchk("status match", ISTA_ADDR, 8'h01);
      chk("irq masked", 17'h0, {16'h0000, IRQ});
      wr(ISTA_ADDR, 8'h01);
      rchk("status cleared", ISTA_ADDR, 8'h00);
      n = 0;
      v = 8'h00;
      while (v[CTRL_OVF_BIT] !== 1'b1 && n < 40000) begin
         rd(CTRL_ADDR, v);
         n++;
      end
      rchk("ctrl overflow", CTRL_ADDR, 8'hC3);
      repeat (4) @(posedge CLK);
      chk("width mod0", 17'd65534, width[0]);
      chk("width mod1", 17'd2, width[1]);
      chk("width mod2", 17'd0, width[2]);
      // compare low byte is rewritten once the match interrupt is seen
      n = 0;
      v = 8'h00;
      while (v[0] !== 1'b1 && n < 40000) begin
         rd(ISTA_ADDR, v);
         n++;
      end
      wr(CMPL_BASE, 8'h02);
      repeat (3) @(posedge CLK);
      #1;
      chk("pin0 disabled", 17'h0, {16'h0000, MODULE_OUTPUT_PIN[0]});
      $display("test pulse done");
      wr(CTRL_ADDR, 8'h00);
      rchk("ctrl cleared", CTRL_ADDR, 8'h00);
      rd(CNTL_ADDR, c0);
      rd(CNTL_ADDR, c1);
      chk("stopped count", {9'h000, c0}, {9'h000, c1});
      wr(IMSK_ADDR, 8'h09);
      #1;
      chk("irq raised", 17'h1, {16'h0000, IRQ});
      rchk("status both", ISTA_ADDR, 8'h09);
      wr(ISTA_ADDR, 8'h01);
      rchk("status w1c", ISTA_ADDR, 8'h08);
      chk("irq overflow", 17'h1, {16'h0000, IRQ});
      wr(ISTA_ADDR, 8'h08);
      #1;
      chk("irq cleared", 17'h0, {16'h0000, IRQ});
      $display("test interrupt done");
      close_out();
   end
endmodule
`default_nettype wire
